// *** shared/prc_pkg.sv ***
package prc_pkg;

	// ==========================================================
	// Widths
	localparam int unsigned AddrW = 4;
	localparam int unsigned DataW = 8;
	localparam int unsigned CountW = 4;
	localparam int unsigned HighW = 3;

	// ==========================================================
	// Register offsets
	localparam logic [AddrW-1:0] RegCtrl = 4'h0;
	localparam logic [AddrW-1:0] RegPulse = 4'h1;
	localparam logic [AddrW-1:0] RegStatus = 4'h2;

	// ==========================================================
	// Control register fields
	localparam int unsigned CtrlBinaryBit = 0;
	localparam int unsigned CtrlCascadeBit = 1;
	localparam int unsigned CtrlClearBit = 2;
	localparam logic [2:0] CtrlReset = 3'h0;

	// ==========================================================
	// Pulse register fields (write only, self clearing)
	localparam int unsigned PulseLowBit = 0;
	localparam int unsigned PulseHighBit = 1;

	// ==========================================================
	// Status register fields
	localparam int unsigned StatCountLsb = 0;
	localparam int unsigned StatLoadBit = 4;
	localparam int unsigned StatClearBit = 5;
	localparam int unsigned StatWrapBit = 6;

	// ==========================================================
	// Reset values and last states of the upper stage
	localparam logic [CountW-1:0] CountReset = 4'h0;
	localparam logic [DataW-1:0] RdDataReset = 8'h00;
	localparam logic [HighW-1:0] DecadeHighLast = 3'h4;
	localparam logic [HighW-1:0] BinaryHighLast = 3'h7;

	// ==========================================================
	// Upper stage variant, chosen at run time by the control register
	typedef enum logic [0:0] {
		PRC_DECADE = 1'b0,
		PRC_BINARY = 1'b1
	} prc_variant_e;

	// ==========================================================
	// Stage action, in priority order
	typedef enum logic [1:0] {
		PRC_ACT_CLEAR = 2'b00,
		PRC_ACT_LOAD = 2'b01,
		PRC_ACT_COUNT = 2'b10,
		PRC_ACT_HOLD = 2'b11
	} prc_action_e;

endpackage

// *** logic/prc_fall_detect.sv ***
`timescale 1ns/10ps

module prc_fall_detect (
	input wire logic clk, // System clock
	input wire logic reset, // Synchronous reset, active high
	input wire logic clkEn, // Clock enable
	input wire logic sigIn, // Stage clock level, synchronous
	output logic fallPulse // One-cycle pulse on a high-to-low step
);

	logic prev_q;

	// ==========================================================
	// Previous level; starts low so reset never fakes an edge
	always_ff @(posedge clk) begin
		if (reset) begin
			prev_q <= 1'b0;
		end else if (clkEn) begin
			prev_q <= sigIn;
		end
	end

	assign fallPulse = clkEn & prev_q & ~sigIn;

endmodule

// *** logic/prc_counter_latch.sv ***
`timescale 1ns/10ps


module prc_counter_latch
	import prc_pkg::*;
(
	input wire logic clk, // System clock, 20 MHz
	input wire logic reset, // Synchronous reset, active high
	input wire logic clkEn, // Clock enable, freezes all state when low
	input wire logic countClkLow, // Count clock of the divide-by-two stage
	input wire logic countClkHigh, // Count clock of the upper stage
	input wire logic loadN, // Parallel load strobe, active low
	input wire logic clearN, // Clear, active low
	input wire logic [prc_pkg::CountW-1:0] presetData, // Preset value
	output logic [prc_pkg::CountW-1:0] countOut, // Counter outputs, bit 0 = low stage
	input wire logic [prc_pkg::AddrW-1:0] regAddr, // Register address
	input wire logic [prc_pkg::DataW-1:0] regWrData, // Register write data
	input wire logic regWr, // Register write strobe
	input wire logic regRd, // Register read strobe
	output logic [prc_pkg::DataW-1:0] regRdData // Read data, cycle after strobe
);

	import prc_pkg::*;

	// ==========================================================
	// Declarations
	logic [2:0] ctrl_q;
	logic lowBit_q;
	logic lowBit_d;
	logic [HighW-1:0] high_q;
	logic [HighW-1:0] high_d;
	logic wrap_q;
	logic [DataW-1:0] rdData_q;
	logic [1:0] stageClk;
	logic [1:0] stageFall;
	logic pulseLow;
	logic pulseHigh;
	logic stepLow;
	logic stepHigh;
	logic cascadeFall;
	logic clearReq;
	logic loadReq;
	logic highWraps;
	prc_variant_e variant;
	prc_action_e lowAct;
	prc_action_e highAct;
	logic [DataW-1:0] statusWord;

	// ==========================================================
	// Helpers
	function automatic logic regHit(input logic [AddrW-1:0] addr,
			input logic [AddrW-1:0] offset);
		regHit = (addr == offset);
	endfunction

	function automatic prc_action_e pickAction(input logic clr, input logic ld,
			input logic step);
		if (clr) begin
			pickAction = PRC_ACT_CLEAR;
		end else if (ld) begin
			pickAction = PRC_ACT_LOAD;
		end else if (step) begin
			pickAction = PRC_ACT_COUNT;
		end else begin
			pickAction = PRC_ACT_HOLD;
		end
	endfunction

	// ==========================================================
	// Falling-edge detection of both stage clocks
	assign stageClk = {countClkHigh, countClkLow};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_fall
			prc_fall_detect u_fall (
				.clk(clk),
				.reset(reset),
				.clkEn(clkEn),
				.sigIn(stageClk[gi]),
				.fallPulse(stageFall[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Control decode
	assign variant = prc_variant_e'(ctrl_q[CtrlBinaryBit]);
	assign clearReq = ~clearN | ctrl_q[CtrlClearBit];
	assign loadReq = ~loadN;

	assign pulseLow = clkEn & regWr & regHit(regAddr, RegPulse) & regWrData[PulseLowBit];
	assign pulseHigh = clkEn & regWr & regHit(regAddr, RegPulse) & regWrData[PulseHighBit];

	// Internal cascade: the low output stepping 1 to 0 clocks the upper stage
	assign cascadeFall = ctrl_q[CtrlCascadeBit] & stepLow & lowBit_q;

	assign stepLow = stageFall[0] | pulseLow;
	assign stepHigh = stageFall[1] | pulseHigh | cascadeFall;

	assign lowAct = pickAction(clearReq, loadReq, stepLow);
	assign highAct = pickAction(clearReq, loadReq, stepHigh);

	// ==========================================================
	// Upper stage wrap point: five states for decade, eight for binary
	always_comb begin
		unique case (variant)
			PRC_DECADE: highWraps = (high_q >= DecadeHighLast);
			PRC_BINARY: highWraps = (high_q == BinaryHighLast);
		endcase
	end

	// ==========================================================
	// Next values of the two stages
	always_comb begin
		unique case (lowAct)
			PRC_ACT_CLEAR: lowBit_d = 1'b0;
			PRC_ACT_LOAD: lowBit_d = presetData[0];
			PRC_ACT_COUNT: lowBit_d = ~lowBit_q;
			PRC_ACT_HOLD: lowBit_d = lowBit_q;
		endcase
	end

	always_comb begin
		unique case (highAct)
			PRC_ACT_CLEAR: high_d = '0;
			PRC_ACT_LOAD: high_d = presetData[CountW-1:1];
			PRC_ACT_COUNT: begin
				if (highWraps) begin
					high_d = '0;
				end else begin
					high_d = HighW'(high_q + 3'h1);
				end
			end
			PRC_ACT_HOLD: high_d = high_q;
		endcase
	end

	// ==========================================================
	// Stage registers
	always_ff @(posedge clk) begin
		if (reset) begin
			lowBit_q <= CountReset[0];
		end else if (clkEn) begin
			lowBit_q <= lowBit_d;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			high_q <= CountReset[CountW-1:1];
		end else if (clkEn) begin
			high_q <= high_d;
		end
	end

	assign countOut = {high_q, lowBit_q};

	// ==========================================================
	// Control register
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q <= CtrlReset;
		end else if (clkEn && regWr && regHit(regAddr, RegCtrl)) begin
			ctrl_q <= regWrData[2:0];
		end
	end

	// ==========================================================
	// Sticky wrap flag: set on an upper-stage wrap, write one to clear;
	// a wrap in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (reset) begin
			wrap_q <= 1'b0;
		end else if (clkEn) begin
			if (highAct == PRC_ACT_COUNT && highWraps) begin
				wrap_q <= 1'b1;
			end else if (regWr && regHit(regAddr, RegStatus) && regWrData[StatWrapBit]) begin
				wrap_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Read path
	always_comb begin
		statusWord = '0;
		statusWord[StatCountLsb +: CountW] = {high_q, lowBit_q};
		statusWord[StatLoadBit] = loadReq;
		statusWord[StatClearBit] = clearReq;
		statusWord[StatWrapBit] = wrap_q;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdData_q <= RdDataReset;
		end else if (clkEn) begin
			if (regRd && regHit(regAddr, RegCtrl)) begin
				rdData_q <= {5'h00, ctrl_q};
			end else if (regRd && regHit(regAddr, RegStatus)) begin
				rdData_q <= statusWord;
			end else begin
				rdData_q <= RdDataReset;
			end
		end
	end

	assign regRdData = rdData_q;

endmodule

// *** sim/prc_counter_latch_chk.sv ***
`timescale 1ns/10ps
// ====
// Port checks
module prc_counter_latch_chk
	import prc_pkg::*;
(
	input wire logic clk, // clock
	input wire logic reset, // reset
	input wire logic clkEn, // enable
	input wire logic countClkLow, // low clock
	input wire logic countClkHigh, // upper clock
	input wire logic loadN, // load
	input wire logic clearN, // clear
	input wire logic [prc_pkg::CountW-1:0] presetData, // preset
	input wire logic [prc_pkg::CountW-1:0] countOut, // count
	input wire logic [prc_pkg::AddrW-1:0] regAddr, // address
	input wire logic [prc_pkg::DataW-1:0] regWrData, // write data
	input wire logic regWr, // write
	input wire logic regRd, // read
	input wire logic [prc_pkg::DataW-1:0] regRdData // read data
);
	logic [2:0] ctrl_q, prev_q;
	logic fl, fh, ok;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	always_ff @(posedge clk) begin
		prev_q <= {countClkLow, countClkHigh, clkEn && !reset && !regWr};
		if (reset) ctrl_q <= CtrlReset;
		else if (clkEn && regWr && regAddr == RegCtrl) ctrl_q <= regWrData[2:0];
	end
	// Quiet cycle: no load, clear, bus write or cascade to explain a change
	assign fl = prev_q[2] && !countClkLow;
	assign fh = prev_q[1] && !countClkHigh;
	assign ok = prev_q[0] && clkEn && !regWr && clearN && loadN && ctrl_q[2:1] == 2'h0;
	property p_clear; clkEn && !clearN |=> countOut == 4'h0; endproperty
	a_clear: assert property (p_clear) else $error("clear");
	property p_prio; clkEn && !loadN && (!clearN || ctrl_q[2]) |=> countOut == 4'h0; endproperty
	a_prio: assert property (p_prio) else $error("priority");
	property p_load; clkEn && clearN && !ctrl_q[2] && !loadN |=> countOut == $past(presetData);
	endproperty
	a_load: assert property (p_load) else $error("load");
	property p_keep; ok && !fl && !fh |=> $stable(countOut); endproperty
	a_keep: assert property (p_keep) else $error("keep");
	property p_low; ok && fl && !fh |=> countOut[0] != $past(countOut[0]) && $stable(countOut[3:1]);
	endproperty
	a_low: assert property (p_low) else $error("low");
	property p_high; ok && fh && !fl |=> $stable(countOut[0]) && !$stable(countOut[3:1]);
	endproperty
	a_high: assert property (p_high) else $error("high");
	property p_dec; ok && fh && !ctrl_q[0] && countOut[3:1] >= 3'h4 |=> countOut[3:1] == 3'h0;
	endproperty
	a_dec: assert property (p_dec) else $error("decade");
	property p_bin; ok && fh && ctrl_q[0] |=> countOut[3:1] == $past(countOut[3:1]) + 3'h1;
	endproperty
	a_bin: assert property (p_bin) else $error("binary");
endmodule
bind prc_counter_latch prc_counter_latch_chk prc_counter_latch_chk_inst (.clk, .reset, .clkEn,
	.countClkLow, .countClkHigh, .loadN, .clearN, .presetData, .countOut, .regAddr, .regWrData,
	.regWr, .regRd, .regRdData);

// *** sim/prc_far_side.sv ***
`timescale 1ns/10ps
// ====
// Count pulse source
module prc_far_side (
	input wire logic clk, // clock
	input wire logic stepLow, // low request
	input wire logic stepHigh, // upper request
	input wire logic ripple, // bit 0 to upper clock
	input wire logic lowBit, // count bit 0
	output logic countClkLow, // low clock
	output logic countClkHigh // upper clock
);
	logic high_q;
	always @(posedge clk) countClkLow <= stepLow;
	always @(posedge clk) high_q <= stepHigh;
	assign countClkHigh = ripple ? lowBit : high_q;
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/10ps
// ====
// Bench
module testbench;
	import prc_pkg::*;
	logic clk = 1'b0, reset = 1'b1, clkEn = 1'b1, loadN = 1'b1, clearN = 1'b1;
	logic regWr = 1'b0, regRd = 1'b0, stepLow = 1'b0, stepHigh = 1'b0, ripple = 1'b0;
	logic countClkLow, countClkHigh;
	logic [3:0] presetData = 4'h0, regAddr = 4'h0, countOut;
	logic [7:0] regWrData = 8'h00, regRdData, rdVal;
	int badCount = 0, checksDone = 0;
	prc_counter_latch prc_counter_latch_inst (.clk, .reset, .clkEn, .countClkLow,
		.countClkHigh, .loadN, .clearN, .presetData, .countOut, .regAddr, .regWrData,
		.regWr, .regRd, .regRdData);
	prc_far_side prc_far_side_inst (.clk, .stepLow, .stepHigh, .ripple,
		.lowBit(countOut[0]), .countClkLow, .countClkHigh);
	initial forever #25 clk = ~clk;
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp) begin
			badCount++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		cyc(1);
		regWr <= w;
		regRd <= !w;
		regAddr <= a;
		regWrData <= d;
		cyc(1);
		regWr <= 1'b0;
		regRd <= 1'b0;
		cyc(1);
		rdVal = regRdData;
	endtask
	task step(input logic hi);
		cyc(1);
		stepLow <= !hi;
		stepHigh <= hi;
		cyc(1);
		stepLow <= 1'b0;
		stepHigh <= 1'b0;
		cyc(5);
	endtask
	task wrapUp;
		if (badCount == 0 && checksDone > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task t_load;
		loadN <= 1'b0;
		presetData <= 4'h9;
		step(1'b0);
		chk(8'(countOut), 8'h09);
		presetData <= 4'h6;
		step(1'b1);
		chk(8'(countOut), 8'h06);
		clearN <= 1'b0;
		cyc(2);
		chk(8'(countOut), 8'h00);
		clearN <= 1'b1;
		cyc(2);
		chk(8'(countOut), 8'h06);
		loadN <= 1'b1;
		step(1'b0);
		chk(8'(countOut), 8'h07);
	endtask
	task t_dec;
		ripple <= 1'b1;
		for (int i = 8; i < 18; i++) begin
			step(1'b0);
			chk(8'(countOut), 8'(i % 10));
		end
	endtask
	task t_bin;
		bus(1'b1, RegCtrl, 8'h01);
		for (int i = 8; i < 24; i++) begin
			step(1'b0);
			chk(8'(countOut), 8'(i % 16));
		end
		loadN <= 1'b0;
		presetData <= 4'h1;
		ripple <= 1'b0;
		cyc(2);
		loadN <= 1'b1;
		for (int i = 1; i < 9; i++) begin
			step(1'b1);
			chk(8'(countOut), 8'(i % 8 * 2 + 1));
		end
		clearN <= 1'b0;
		cyc(2);
		chk(8'(countOut), 8'h00);
		clearN <= 1'b1;
	endtask
	task t_regs;
		bus(1'b0, 4'hF, 8'h00);
		chk(rdVal, 8'h00);
		bus(1'b1, RegPulse, 8'h01);
		bus(1'b1, RegPulse, 8'h02);
		cyc(3);
		chk(8'(countOut), 8'h03);
		bus(1'b0, RegStatus, 8'h00);
		chk(rdVal, 8'h43);
		bus(1'b1, RegStatus, 8'h40);
		bus(1'b1, RegCtrl, 8'h05);
		bus(1'b0, RegStatus, 8'h00);
		chk(rdVal, 8'h20);
	endtask
	task t_more;
		bus(1'b1, RegCtrl, 8'h02);
		for (int i = 1; i < 11; i++) begin
			step(1'b0);
			chk(8'(countOut), 8'(i % 10));
		end
		clkEn <= 1'b0;
		step(1'b0);
		chk(8'(countOut), 8'h00);
		clkEn <= 1'b1;
		cyc(2);
		step(1'b0);
		chk(8'(countOut), 8'h01);
		bus(1'b0, RegCtrl, 8'h00);
		chk(rdVal, 8'h02);
		cyc(1);
		chk(regRdData, 8'h00);
		bus(1'b0, RegPulse, 8'h00);
		chk(rdVal, 8'h00);
	endtask
	initial begin
		cyc(8);
		reset <= 1'b0;
		t_load;
		t_dec;
		t_bin;
		t_regs;
		t_more;
		wrapUp;
	end
endmodule
